/* File: core/tdl_core.v */
// Time-of-day accumulator with latches, triggers and pulse-width frame link
`timescale 1ns/1ns
`include "tdl_regs.vh"
module tdl_core #(
    parameter GPIO_N = 4,
    parameter CH_N = 4,
    parameter PER_W = 16,
    parameter FIFO_DEPTH = 4,
    parameter FIFO_AW = 2
) (
    input wire clock,
    input wire rst_n,
    input wire sw_wr_en,
    input wire sw_rd_en,
    input wire [7:0] sw_addr,
    input wire [7:0] sw_wr_data,
    input wire [7:0] trig_addr,
    input wire reg_fifo_pop,
    input wire smp_fifo_pop,
    input wire [`TDL_SRC_N-1:0] arm,
    input wire [`TDL_SRC_N-1:0] arm_cont,
    input wire timer_start,
    input wire [31:0] timer_count,
    input wire timer_load_mode,
    input wire sync_pulse,
    input wire [GPIO_N-1:0] gpio_in,
    input wire [GPIO_N-1:0] gpio_dir,
    input wire [GPIO_N-1:0] gpio_latch_sel,
    input wire [`TDL_TOD_W-1:0] cmp_time,
    input wire [CH_N:0] chan_clk,
    input wire [2:0] enc_chan_sel,
    input wire [2:0] fwd_chan_sel,
    input wire carrier_in,
    input wire pps_frame_en,
    input wire reply_en,
    output reg [7:0] sw_rd_data,
    output reg [`TDL_TOD_W-1:0] tod_now,
    output reg pps_out,
    output reg [`TDL_TOD_W-1:0] reg_fifo_data,
    output reg reg_fifo_valid,
    output reg [`TDL_TOD_W-1:0] smp_fifo_data,
    output reg smp_fifo_valid,
    output reg [`TDL_TOD_W-1:0] latch_time_a,
    output reg [`TDL_TOD_W-1:0] latch_time_b,
    output reg [GPIO_N-1:0] gpio_out,
    output reg [GPIO_N-1:0] gpio_oe,
    output wire pwm_out,
    output reg [CH_N:0] fwd_carrier,
    output reg [CH_N:0] fwd_frame_valid,
    output reg [`TDL_TOD_W-1:0] rx_frame_time
);
    localparam AS_N = GPIO_N + CH_N + 3;
    localparam IX_SYNC = GPIO_N;
    localparam IX_CAR = GPIO_N + 1;
    localparam IX_CH = GPIO_N + 2;

    // Two-stage synchronisers plus an edge stage for the pin, sync, carrier and channel clock inputs
    wire [AS_N-1:0] as_in = {chan_clk, carrier_in, sync_pulse, gpio_in};
    reg [AS_N-1:0] as_s1;
    reg [AS_N-1:0] as_s2;
    reg [AS_N-1:0] as_s3;
    wire [AS_N-1:0] as_rise = as_s2 & ~as_s3;
    genvar gi;
    generate
        for (gi = 0; gi < AS_N; gi = gi + 1) begin : g_sync
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) begin
                    as_s1[gi] <= 1'b0;
                    as_s2[gi] <= 1'b0;
                    as_s3[gi] <= 1'b0;
                end else begin
                    as_s1[gi] <= as_in[gi];
                    as_s2[gi] <= as_s1[gi];
                    as_s3[gi] <= as_s2[gi];
                end
            end
        end
    endgenerate
    wire sync_rise = as_rise[IX_SYNC];
    wire car_rise = as_rise[IX_CAR];
    wire car_lvl = as_s2[IX_CAR];
    wire [GPIO_N-1:0] gpio_rise = as_rise[GPIO_N-1:0] & ~gpio_dir;

    // Software access decode
    wire wr_msb = sw_wr_en && (sw_addr == `TDL_ADDR_TODMSB);
    wire rd_prev = sw_rd_en && (sw_addr == `TDL_ADDR_PREV);
    wire in_tod = (sw_addr >= `TDL_ADDR_TOD0) && (sw_addr <= `TDL_ADDR_TODMSB);
    wire [3:0] byte_ix = sw_addr[3:0];
    wire trig_hit = (sw_wr_en || sw_rd_en) && (sw_addr == trig_addr);

    // Countdown timer, one step per system clock
    reg [31:0] timer;
    reg timer_run;
    wire timer_exp = timer_run && (timer == 32'h00000001);
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            timer <= 32'h00000000;
            timer_run <= 1'b0;
        end else if (timer_start) begin
            timer <= timer_count;
            timer_run <= (timer_count != 32'h00000000);
        end else if (timer_run) begin
            timer <= timer - 32'h00000001;
            if (timer_exp) timer_run <= 1'b0;
        end
    end

    // Frame decoder state (declared here, used by arming)
    reg rx_done;
    reg [`TDL_FRAME_BITS-1:0] rx_frame;

    // Once or continuous arming per edge source; a new arm wins over a clear
    wire [`TDL_SRC_N-1:0] src_evt = {timer_exp, |gpio_rise, rx_done, sync_rise, sync_rise};
    reg [`TDL_SRC_N-1:0] armed;
    wire [`TDL_SRC_N-1:0] fire = armed & src_evt;
    generate
        for (gi = 0; gi < `TDL_SRC_N; gi = gi + 1) begin : g_arm
            always @(posedge clock or negedge rst_n) begin
                if (!rst_n) armed[gi] <= 1'b0;
                else if (arm[gi]) armed[gi] <= 1'b1;
                else if (src_evt[gi] && !arm_cont[gi]) armed[gi] <= 1'b0;
            end
        end
    endgenerate

    // Staged time register and readable snapshot
    reg [`TDL_TOD_W-1:0] staged;
    reg [`TDL_TOD_W-1:0] snap;
    reg [`TDL_TOD_W-1:0] next_acc;
    reg pps_evt;
    wire [`TDL_NS_W-1:0] acc_ns = tod_now[`TDL_SEC_LSB-1:`TDL_NS_LSB];
    wire [`TDL_SEC_W-1:0] acc_sec = tod_now[`TDL_TOD_W-1:`TDL_SEC_LSB];
    wire roll = (acc_ns >= `TDL_NS_ROLL - `TDL_CLK_PERIOD_NS);
    wire timer_ld = timer_exp && armed[`TDL_SRC_TIMER] && timer_load_mode;

    // Accumulator next value; software write wins, then pulse, frame, timer
    always @* begin
        pps_evt = 1'b0;
        if (wr_msb) begin
            next_acc = {sw_wr_data, staged[`TDL_TOD_W-9:0]};
        end else if (fire[`TDL_SRC_SYNC_LOAD]) begin
            next_acc = staged;
        end else if (fire[`TDL_SRC_FRAME_LOAD]) begin
            next_acc = rx_frame[`TDL_TOD_W-1:0];
        end else if (timer_ld) begin
            next_acc = staged;
        end else if (roll) begin
            // Fraction keeps its value: the step is a whole number of ns
            next_acc = {acc_sec + 48'h000000000001, 32'h00000000, tod_now[7:0]};
            pps_evt = 1'b1;
        end else begin
            next_acc = {acc_sec, acc_ns + `TDL_CLK_PERIOD_NS, tod_now[7:0]};
        end
    end

    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tod_now <= {`TDL_TOD_W{1'b0}};
            pps_out <= 1'b0;
        end else begin
            tod_now <= next_acc;
            pps_out <= pps_evt;
        end
    end

    // Staging writes and read snapshot; reads of the time bytes return the snapshot
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            staged <= {`TDL_TOD_W{1'b0}};
            snap <= {`TDL_TOD_W{1'b0}};
            sw_rd_data <= 8'h00;
        end else begin
            if (sw_wr_en && in_tod) staged[byte_ix*8 +: 8] <= sw_wr_data;
            if (rd_prev) snap <= tod_now;
            if (sw_rd_en && in_tod) sw_rd_data <= snap[byte_ix*8 +: 8];
            else if (sw_rd_en) sw_rd_data <= 8'h00;
        end
    end

    // Programmed-address capture FIFO
    wire [`TDL_TOD_W-1:0] rf_dout;
    wire rf_valid;
    tdl_fifo #(.W(`TDL_TOD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_reg_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .push(trig_hit),
        .din(tod_now),
        .pop(reg_fifo_pop),
        .dout(rf_dout),
        .valid(rf_valid),
        .full()
    );

    // Sample FIFO: one capture per cycle, sync, pin and timer events merged into one push
    wire cap_sync = fire[`TDL_SRC_SYNC_CAP];
    wire cap_gpio = fire[`TDL_SRC_GPIO_CAP];
    wire cap_timer = fire[`TDL_SRC_TIMER] && !timer_load_mode;
    wire [`TDL_TOD_W-1:0] sf_dout;
    wire sf_valid;
    tdl_fifo #(.W(`TDL_TOD_W), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_smp_fifo (
        .clock(clock),
        .rst_n(rst_n),
        .push(cap_sync | cap_gpio | cap_timer),
        .din(tod_now),
        .pop(smp_fifo_pop),
        .dout(sf_dout),
        .valid(sf_valid),
        .full()
    );

    // Registered FIFO views; they trail a pop by two cycles
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            reg_fifo_data <= {`TDL_TOD_W{1'b0}};
            reg_fifo_valid <= 1'b0;
            smp_fifo_data <= {`TDL_TOD_W{1'b0}};
            smp_fifo_valid <= 1'b0;
        end else begin
            reg_fifo_data <= rf_dout;
            reg_fifo_valid <= rf_valid;
            smp_fifo_data <= sf_dout;
            smp_fifo_valid <= sf_valid;
        end
    end

    // Trigger pins: inputs latch into the assigned register, outputs compare
    integer pi;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            latch_time_a <= {`TDL_TOD_W{1'b0}};
            latch_time_b <= {`TDL_TOD_W{1'b0}};
            gpio_out <= {GPIO_N{1'b0}};
            gpio_oe <= {GPIO_N{1'b0}};
        end else begin
            gpio_oe <= gpio_dir;
            for (pi = 0; pi < GPIO_N; pi = pi + 1) begin
                if (gpio_rise[pi] && gpio_latch_sel[pi]) latch_time_b <= tod_now;
                else if (gpio_rise[pi]) latch_time_a <= tod_now;
                // Compare ignores the fraction, which only loads and writes change
                gpio_out[pi] <= gpio_dir[pi] &&
                    (tod_now[`TDL_TOD_W-1:`TDL_NS_LSB] >= cmp_time[`TDL_TOD_W-1:`TDL_NS_LSB]);
            end
        end
    end

    // Decoder: classify each carrier period by its high time
    reg [PER_W-1:0] rx_per;
    reg [PER_W-1:0] rx_hi;
    reg [`TDL_FRAME_BITS-2:0] rx_shift;
    reg [6:0] rx_cnt;
    reg [1:0] rx_sym;
    wire [PER_W+3:0] hi8 = {1'b0, rx_hi, 3'h0};
    wire [PER_W+3:0] per_lo = rx_per * `TDL_THR_LO;
    wire [PER_W+3:0] per_hi = rx_per * `TDL_THR_HI;
    always @* begin
        if (hi8 < per_lo) rx_sym = `TDL_SYM_ZERO;
        else if (hi8 > per_hi) rx_sym = `TDL_SYM_ONE;
        else rx_sym = `TDL_SYM_SPACE;
    end

    // Frames are runs of data symbols; a space resets the bit count
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rx_per <= {PER_W{1'b0}};
            rx_hi <= {PER_W{1'b0}};
            rx_shift <= {(`TDL_FRAME_BITS-1){1'b0}};
            rx_cnt <= 7'h00;
            rx_done <= 1'b0;
            rx_frame <= {`TDL_FRAME_BITS{1'b0}};
        end else begin
            rx_done <= 1'b0;
            if (car_rise) begin
                // Counter width covers the slowest carrier period
                rx_per <= {{(PER_W-1){1'b0}}, 1'b1};
                rx_hi <= {{(PER_W-1){1'b0}}, 1'b1};
                if (rx_sym == `TDL_SYM_SPACE) begin
                    rx_cnt <= 7'h00;
                end else if (rx_cnt == `TDL_FRAME_LAST) begin
                    rx_frame <= {rx_shift, rx_sym == `TDL_SYM_ONE};
                    rx_done <= 1'b1;
                    rx_cnt <= 7'h00;
                end else begin
                    rx_shift <= {rx_shift[`TDL_FRAME_BITS-3:0], rx_sym == `TDL_SYM_ONE};
                    rx_cnt <= rx_cnt + 7'h01;
                end
            end else begin
                rx_per <= rx_per + 1'b1;
                if (car_lvl) rx_hi <= rx_hi + 1'b1;
            end
        end
    end

    // Forward recovered carrier and frames to the chosen channel
    integer ci;
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            fwd_carrier <= {(CH_N+1){1'b0}};
            fwd_frame_valid <= {(CH_N+1){1'b0}};
            rx_frame_time <= {`TDL_TOD_W{1'b0}};
        end else begin
            for (ci = 0; ci <= CH_N; ci = ci + 1) begin
                fwd_carrier[ci] <= car_lvl && (fwd_chan_sel == ci);
                fwd_frame_valid[ci] <= rx_done && (fwd_chan_sel == ci);
            end
            if (rx_done) rx_frame_time <= rx_frame[`TDL_TOD_W-1:0];
        end
    end

    // Transmit request: second pulse or reply, held until the encoder takes it
    reg tx_pend;
    reg [`TDL_FRAME_BITS-1:0] tx_frame;
    wire enc_busy;
    wire reply_req = rx_done && rx_frame[`TDL_FRAME_REQ] && reply_en;
    // Second boundary may be asynchronous to the carrier, so it rides in a frame when pps_frame_en is set
    wire pps_req = pps_evt && pps_frame_en;
    wire enc_car_rise = as_rise[IX_CH + enc_chan_sel];
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            tx_pend <= 1'b0;
            tx_frame <= {`TDL_FRAME_BITS{1'b0}};
        end else if (pps_req || reply_req) begin
            tx_pend <= 1'b1;
            tx_frame <= {1'b0, tod_now};
        end else if (tx_pend && enc_car_rise && !enc_busy) begin
            tx_pend <= 1'b0;
        end
    end

    tdl_pwm_enc #(.PER_W(PER_W)) u_enc (
        .clock(clock),
        .rst_n(rst_n),
        .car_rise(enc_car_rise),
        .tx_start(tx_pend),
        .tx_frame(tx_frame),
        .pwm_out(pwm_out),
        .busy(enc_busy)
    );
endmodule // tdl_core

/* File: core/tdl_fifo.v */
// Flip-flop FIFO for captured time words
`timescale 1ns/1ns
module tdl_fifo #(
    parameter W = 88,
    parameter DEPTH = 4,
    parameter AW = 2
) (
    input wire clock,
    input wire rst_n,
    input wire push,
    input wire [W-1:0] din,
    input wire pop,
    output wire [W-1:0] dout,
    output wire valid,
    output wire full
);
    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr;
    reg [AW-1:0] rd_ptr;
    reg [AW:0] count;
    wire do_push = push & ~full;
    wire do_pop = pop & valid;

    assign dout = mem[rd_ptr];
    assign valid = (count != {(AW+1){1'b0}});
    assign full = (count == DEPTH[AW:0]);

    // Storage, written only at the tail; a push into a full FIFO is dropped
    always @(posedge clock) begin
        if (do_push) begin
            mem[wr_ptr] <= din;
        end
    end

    // Pointers and fill level
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wr_ptr <= {AW{1'b0}};
            rd_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (do_push) wr_ptr <= wr_ptr + 1'b1;
            if (do_pop) rd_ptr <= rd_ptr + 1'b1;
            if (do_push && !do_pop) count <= count + 1'b1;
            else if (do_pop && !do_push) count <= count - 1'b1;
        end
    end
endmodule // tdl_fifo

/* File: core/tdl_pwm_enc.v */
// Pulse-width symbol encoder on a sampled carrier
`timescale 1ns/1ns
`include "tdl_regs.vh"
module tdl_pwm_enc #(
    parameter PER_W = 16
) (
    input wire clock,
    input wire rst_n,
    input wire car_rise,
    input wire tx_start,
    input wire [`TDL_FRAME_BITS-1:0] tx_frame,
    output reg pwm_out,
    output wire busy
);
    reg [PER_W-1:0] per_cnt;
    reg [PER_W-1:0] period;
    reg [PER_W-1:0] fall_at;
    reg [`TDL_FRAME_BITS-1:0] shift;
    reg [6:0] left;
    reg [1:0] next_sym;

    assign busy = (left != 7'h00);

    // Symbol for the period that starts now
    always @* begin
        if (left == 7'h00) next_sym = `TDL_SYM_SPACE;
        else if (shift[`TDL_FRAME_BITS-1]) next_sym = `TDL_SYM_ONE;
        else next_sym = `TDL_SYM_ZERO;
    end

    // Rising edge passes straight; falling edge placed by symbol duty
    always @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pwm_out <= 1'b0;
            per_cnt <= {PER_W{1'b0}};
            period <= {PER_W{1'b0}};
            fall_at <= {PER_W{1'b0}};
            shift <= {`TDL_FRAME_BITS{1'b0}};
            left <= 7'h00;
        end else if (car_rise) begin
            pwm_out <= 1'b1;
            per_cnt <= {PER_W{1'b0}};
            period <= per_cnt + 1'b1;
            // Duty uses the period stored one edge earlier, so the first two after reset are rough
            case (next_sym)
                `TDL_SYM_ZERO: fall_at <= period >> 2;
                `TDL_SYM_ONE: fall_at <= period - (period >> 2);
                default: fall_at <= period >> 1;
            endcase
            if (left != 7'h00) begin
                shift <= {shift[`TDL_FRAME_BITS-2:0], 1'b0};
                left <= left - 1'b1;
            end else if (tx_start) begin
                shift <= tx_frame;
                left <= `TDL_FRAME_LAST + 7'h01;
            end
        end else begin
            per_cnt <= per_cnt + 1'b1;
            if (per_cnt + 1'b1 >= fall_at) pwm_out <= 1'b0;
        end
    end
endmodule // tdl_pwm_enc

/* File: core/tdl_regs.vh */
// Constants for the time-of-day latch, trigger and pulse-width coding block
`ifndef TDL_REGS_VH
`define TDL_REGS_VH
// Time word layout: {seconds, nanoseconds, sub-ns fraction}
`define TDL_TOD_W 88
`define TDL_SEC_W 48
`define TDL_NS_W 32
`define TDL_FRAC_W 8
`define TDL_NS_LSB 8
`define TDL_SEC_LSB 40
`define TDL_BYTES 4'hB
// Software address map of the time register
`define TDL_ADDR_PREV 8'h0F
`define TDL_ADDR_TOD0 8'h10
`define TDL_ADDR_TODMSB 8'h1A
// Nanosecond rollover and system clock step
`define TDL_NS_ROLL 32'h3B9ACA00
`define TDL_CLK_PERIOD_NS 32'h0000000A
// Carrier symbols
`define TDL_SYM_SPACE 2'h0
`define TDL_SYM_ZERO 2'h1
`define TDL_SYM_ONE 2'h2
// Frame: request flag then 88 time bits, MSB first
`define TDL_FRAME_BITS 89
`define TDL_FRAME_LAST 7'h58
`define TDL_FRAME_REQ 88
// Edge-driven source indices
`define TDL_SRC_N 5
`define TDL_SRC_SYNC_CAP 0
`define TDL_SRC_SYNC_LOAD 1
`define TDL_SRC_FRAME_LOAD 2
`define TDL_SRC_GPIO_CAP 3
`define TDL_SRC_TIMER 4
// Decoder duty thresholds in eighths of a period
`define TDL_THR_LO 4'h3
`define TDL_THR_HI 4'h5
`endif

/* File: verif/tdl_check_assertions.sv */
// Port checker for the time-of-day latch block
`timescale 1ns/1ns
module tdl_check #(
    parameter GPIO_N = 4,
    parameter CH_N = 4
) (
    input wire clock,
    input wire rst_n,
    input wire sw_wr_en,
    input wire sw_rd_en,
    input wire [7:0] sw_addr,
    input wire [7:0] sw_wr_data,
    input wire [7:0] trig_addr,
    input wire [7:0] sw_rd_data,
    input wire [87:0] tod_now,
    input wire [87:0] reg_fifo_data,
    input wire reg_fifo_valid,
    input wire [GPIO_N-1:0] gpio_dir,
    input wire [GPIO_N-1:0] gpio_out,
    input wire [87:0] cmp_time,
    input wire [CH_N:0] fwd_frame_valid
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    // Access sequences; only the snapshot read spans several steps
    sequence msb_wr; sw_wr_en && sw_addr == 8'h1A; endsequence
    sequence snap_rd; sw_rd_en && sw_addr == 8'h0F ##1 sw_rd_en && sw_addr == 8'h10
        ##1 sw_rd_en && sw_addr == 8'h11; endsequence
    sequence trig_hit; (sw_wr_en || sw_rd_en) && sw_addr == trig_addr && !reg_fifo_valid; endsequence
    seconds_commit_a: assert property (msb_wr |=> tod_now[87:80] == $past(sw_wr_data))
        else $error("seconds msb write not committed");
    snapshot_byte_a: assert property (snap_rd |=> sw_rd_data == $past(tod_now[15:8], 3))
        else $error("snapshot byte differs from latched time");
    unmapped_zero_a: assert property (sw_rd_en && sw_addr > 8'h1A |=> sw_rd_data == 8'h00)
        else $error("unmapped read not zero");
    read_hold_a: assert property (!sw_rd_en |=> $stable(sw_rd_data))
        else $error("read data moved without a read");
    ns_range_a: assert property (tod_now[39:8] < 32'h3B9ACA00)
        else $error("nanoseconds beyond one second");
    trig_capture_a: assert property (trig_hit |-> ##2 reg_fifo_valid &&
        reg_fifo_data == $past(tod_now, 2))
        else $error("trigger address capture wrong");
    pin_compare_a: assert property (|gpio_out |-> tod_now[87:8] >= cmp_time[87:8])
        else $error("trigger output early");
    pin_dir_a: assert property ((gpio_out & ~gpio_dir & ~$past(gpio_dir)) == 0)
        else $error("trigger output on input pin");
    fwd_single_a: assert property ($onehot0(fwd_frame_valid))
        else $error("frame forwarded to several channels");
endmodule // tdl_check

/* File: verif/tdl_remote.sv */
// Remote device sending coded frames on a free-running carrier
`timescale 1ns/1ns
module tdl_remote (
    input wire send,
    input wire [88:0] frame,
    output reg carrier
);
    int i;
    int hi;
    logic sent;
    // One period per symbol, 80 ns carrier, well above the slowest rate for frames
    initial begin
        carrier = 1'b0;
        i = -1;
        sent = 1'b0;
        #3;
        forever begin
            if (i < 0 && send && !sent) i = 96; // Leading spaces let the far end measure
            sent = send;
            hi = 40;
            if (i >= 0 && i <= 88) hi = frame[i] ? 60 : 20;
            if (i >= 0) i = i - 1;
            carrier = 1'b1;
            #hi;
            carrier = 1'b0;
            #(80 - hi);
        end
    end
endmodule // tdl_remote

/* File: verif/testbench.sv */
// Self-checking bench for the time-of-day latch block
`timescale 1ns/1ns
module testbench;
    logic clock, rst_n, sw_wr_en, sw_rd_en, reg_fifo_pop, smp_fifo_pop, timer_start;
    logic timer_load_mode, sync_pulse, carrier_in, pps_frame_en, reply_en, send;
    logic pps_out, reg_fifo_valid, smp_fifo_valid, pwm_out;
    logic [7:0] sw_addr, sw_wr_data, trig_addr, sw_rd_data;
    logic [4:0] arm, arm_cont, chan_clk, fwd_carrier, fwd_frame_valid, fc;
    logic [31:0] timer_count;
    logic [3:0] gpio_in, gpio_dir, gpio_latch_sel, gpio_out, gpio_oe;
    logic [2:0] enc_chan_sel, fwd_chan_sel, seen;
    logic [87:0] cmp_time, tod_now, reg_fifo_data, smp_fifo_data, latch_time_a;
    logic [87:0] latch_time_b, rx_frame_time, t, w;
    logic [88:0] rframe;
    logic [95:0] rbuf;
    int error_cnt, checks, cyc, cw, cr, n, run, bad;
    tdl_core tdl_core_i (.clock, .rst_n, .sw_wr_en, .sw_rd_en, .sw_addr, .sw_wr_data,
        .trig_addr, .reg_fifo_pop, .smp_fifo_pop, .arm, .arm_cont, .timer_start,
        .timer_count, .timer_load_mode, .sync_pulse, .gpio_in, .gpio_dir, .gpio_latch_sel,
        .cmp_time, .chan_clk, .enc_chan_sel, .fwd_chan_sel, .carrier_in, .pps_frame_en,
        .reply_en, .sw_rd_data, .tod_now, .pps_out, .reg_fifo_data, .reg_fifo_valid,
        .smp_fifo_data, .smp_fifo_valid, .latch_time_a, .latch_time_b, .gpio_out, .gpio_oe,
        .pwm_out, .fwd_carrier, .fwd_frame_valid, .rx_frame_time);
    tdl_remote tdl_remote_i (.send, .frame(rframe), .carrier(carrier_in));
    // Clocks: system and encoder channel
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    initial begin
        chan_clk = 5'h00;
        forever #40 chan_clk[4] = ~chan_clk[4];
    end
    always @(posedge clock) cyc <= cyc + 1;
    task chk(input logic [87:0] got, input logic [87:0] exp);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task summarize;
        if (error_cnt == 0 && checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    function logic pick(input int s);
        case (s)
            0: pick = reg_fifo_valid;
            1: pick = smp_fifo_valid;
            2: pick = fwd_frame_valid[2];
            3: pick = gpio_out[1];
            4: pick = pps_out;
            default: pick = ~pwm_out;
        endcase
    endfunction
    // Bounded wait; running out ends the run
    task wait_bit(input int s, input int lim);
        for (int k = 0; pick(s) !== 1'b1; k++) begin
            if (k > lim) begin
                chk(88'(s), 88'hFF);
                summarize();
            end
            @(negedge clock);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        {sw_addr, sw_wr_data, sw_wr_en, cw} = {a, d, 1'b1, cyc};
        @(negedge clock);
        sw_wr_en = 1'b0;
    endtask
    task wr_time(input logic [87:0] v, input int k0, input int k1);
        for (int k = k0; k <= k1; k++) wr(8'h10 + 8'(k), v[8*k +: 8]);
    endtask
    // Back-to-back reads, bytes shifted in from the top
    task rdb(input logic [7:0] a, input int cnt);
        for (int j = 0; j <= cnt; j++) begin
            @(negedge clock);
            if (j > 0) rbuf = {sw_rd_data, rbuf[95:8]};
            if (j == 0) cr = cyc;
            sw_addr = a + 8'(j);
            sw_rd_en = (j < cnt);
        end
    endtask
    task arm_src(input int b);
        @(negedge clock);
        arm[b] = 1'b1;
        @(negedge clock);
        arm = 5'h00;
    endtask
    task pin(input int g);
        @(negedge clock);
        if (g == 0) sync_pulse = 1'b1; else gpio_in[0] = 1'b1;
        repeat (6) @(negedge clock);
        {sync_pulse, gpio_in} = 5'h00;
        repeat (6) @(negedge clock);
    endtask
    // Drain the sample queue, pops spaced apart
    task pop_cnt;
        {n, w} = 0;
        repeat (8) begin
            repeat (4) @(negedge clock);
            if (smp_fifo_valid === 1'b1) begin
                if (n == 0) w = smp_fifo_data;
                n++;
                smp_fifo_pop = 1'b1;
                @(negedge clock);
                smp_fifo_pop = 1'b0;
            end
        end
    endtask
    initial begin
        {rst_n, sw_wr_en, sw_rd_en, reg_fifo_pop, smp_fifo_pop, timer_start, sync_pulse} = 0;
        {timer_load_mode, pps_frame_en, reply_en, send, arm, arm_cont, gpio_in, gpio_dir} = 0;
        {sw_addr, sw_wr_data, timer_count, gpio_latch_sel, cmp_time, rframe} = 0;
        {error_cnt, checks, cyc, trig_addr, enc_chan_sel, fwd_chan_sel} = {96'h0, 8'h30, 6'h22};
        repeat (20) @(posedge clock);
        @(negedge clock) rst_n = 1'b1;
        t = {48'h0000_0012_3456, 32'h0000_1000, 8'h5A};
        wr_time(t, 0, 9);
        chk(tod_now[87:40], 0);
        wr_time(t, 10, 10);
        chk(tod_now, t);
        rdb(8'h0F, 12);
        chk(rbuf[95:8], t + (88'(10 * (cr - cw - 1)) << 8));
        wr(8'h30, 8'hFF);
        wait_bit(0, 4);
        chk(reg_fifo_data[87:40], t[87:40]);
        rdb(8'h30, 1);
        chk(rbuf[95:88], 0);
        repeat (2) begin
            @(negedge clock) reg_fifo_pop = 1'b1;
            @(negedge clock) reg_fifo_pop = 1'b0;
            repeat (3) @(negedge clock);
        end
        chk(reg_fifo_valid, 0);
        // Sync edge capture, once then continuous
        arm_src(0);
        pin(0);
        pin(0);
        pop_cnt();
        chk(88'(n), 1);
        chk(w[87:40], t[87:40]);
        arm_cont = 5'h01;
        arm_src(0);
        pin(0);
        pin(0);
        arm_cont = 5'h00;
        pop_cnt();
        chk(88'(n), 2);
        // Staged seconds loaded on sync edge; the capture disarms after it
        t = {48'h0000_0000_0777, 40'h0};
        wr_time(t, 5, 9);
        arm_src(1);
        pin(0);
        chk(tod_now[87:40], t[87:40]);
        pop_cnt();
        chk(88'(n), 1);
        timer_count = 32'h0000_0064;
        arm_src(4);
        @(negedge clock) timer_start = 1'b1;
        @(negedge clock) timer_start = 1'b0;
        repeat (100) @(negedge clock);
        chk(smp_fifo_valid, 0);
        wait_bit(1, 2);
        pop_cnt();
        gpio_latch_sel = 4'h1;
        arm_src(3);
        pin(1);
        chk(latch_time_b[87:40], t[87:40]);
        chk(latch_time_a, 0);
        pop_cnt();
        chk(88'(n), 1);
        // Compare output and second rollover sending a frame
        t = {48'h0000_0000_0ABC, 32'h3B9AC000, 8'h00};
        cmp_time = t + (88'h7D0 << 8);
        {gpio_dir, pps_frame_en, enc_chan_sel} = {4'h2, 1'b1, 3'h4};
        wr_time(t, 0, 10);
        repeat (150) @(negedge clock);
        chk(gpio_out, 0);
        wait_bit(3, 80);
        chk(gpio_oe, 4'h2);
        wait_bit(4, 120);
        repeat (3) @(negedge clock);
        chk(tod_now[87:40], t[87:40] + 1);
        wait_bit(5, 20);
        {run, bad, seen, fc} = 0;
        repeat (900) begin
            @(negedge clock);
            fc |= fwd_carrier;
            if (pwm_out === 1'b1) run++;
            else if (run > 0) begin
                if (run == 2 || run == 4 || run == 6) seen[run/2-1] = 1'b1; else bad++;
                run = 0;
            end
        end
        chk(88'(bad), 0);
        chk(seen, 3'h7);
        chk(fc, 5'h04);
        // Received frame loads the accumulator
        t = {48'h0000_0000_5555, 32'h0000_2000, 8'h11};
        arm_src(2);
        {rframe, send, reply_en} = {1'b1, t, 2'h3};
        wait_bit(2, 1200);
        chk(rx_frame_time, t);
        send = 1'b0;
        repeat (3) @(negedge clock);
        chk(tod_now[87:40], t[87:40]);
        // Reply opens with a zero flag symbol; the first, possibly cut, pulse is skipped
        run = -99;
        bad = 0;
        repeat (40) begin
            @(negedge clock);
            if (pwm_out === 1'b1) run++;
            else begin
                if (run == 2) bad++;
                run = 0;
            end
        end
        chk(88'(bad != 0), 1);
        summarize();
    end
endmodule // testbench
bind tdl_core tdl_check #(.GPIO_N(GPIO_N), .CH_N(CH_N)) tdl_check_i (.clock, .rst_n,
    .sw_wr_en, .sw_rd_en, .sw_addr, .sw_wr_data, .trig_addr, .sw_rd_data, .tod_now,
    .reg_fifo_data, .reg_fifo_valid, .gpio_dir, .gpio_out, .cmp_time, .fwd_frame_valid);
